/* core/flash_cmd_params.svh */
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// Clock period of the system clock
`define CLK_PERIOD_NS 4
// Least time one byte program occupies the machine
`define PROG_TIME_NS 40
// Value every byte of an erased block reads back as
`define ERASED_BYTE 8'hFF
// Identifier read locations
`define ID_MAKER_ADDR 10'h000
`define ID_DEVICE_ADDR 10'h001
// Reset state of the synchronised pins: {supply ok, protect pin level}
`define PIN_RESET 2'h1

`endif

/* core/flash_cmd_pkg.sv */
package flash_cmd_pkg;

	// Read path selection of the command user interface
	typedef enum logic [1:0] {
		M_ARRAY,
		M_IDENT,
		M_STATUS
	} read_mode_t;

	// Write state machine states
	typedef enum logic [2:0] {
		W_IDLE,
		W_ERASE,
		W_PROG,
		W_ESUSP,
		W_ESUSP_PROG,
		W_PSUSP
	} wsm_state_t;

	// Status byte, bit 7 first
	typedef struct packed {
		logic machine_ready_bit;
		logic erase_suspended_bit;
		logic erase_error_bit;
		logic program_error_bit;
		logic supply_low_bit;
		logic program_suspended_bit;
		logic protect_abort_bit;
		logic reserved;
	} status_t;

	// Sticky error flags
	typedef struct packed {
		logic erase_error;
		logic program_error;
		logic supply_low;
		logic protect_abort;
	} err_flags_t;

endpackage

/* core/flash_command_interface.sv */
`timescale 1ns/1ns
// Behaviour
// - Leaving reset puts the read path in array-read mode.
// - Array-read command selects array data until another command arrives.
// - Array-read command ignored while erase or program is running unsuspended.
// - Identifier mode: location 0 gives maker code, location 1 device code.
// - Read-status command always accepted; reads then return status.
// - Error flags set only by the machine, cleared only by clear-status.
// - Read, identifier, status and clear commands ignore the supply level.
// - Erase clears exactly the addressed block to all ones.
// - After an erase command reads return status until a new command.
// - Erase fails on write-lock or protect pin, cause recorded in status.
// - Program writes one byte at given address; reads return status after.
// - Verify flags only bits meant zero that stayed one.
// - Program fails on write-lock or active protect pin.
// - Erase suspend halts at a checkpoint; reads return status.
// - In erase suspend only array read, program elsewhere, status, resume.
// - Erase resume continues erase, held off until nested program ends.
// - Program suspend halts at a checkpoint; reads return status.
// - In program suspend only array read elsewhere, status, resume.
// - Bit 7 reads one when machine idle, zero while busy.
// - Bit 6 shows erase suspended, bit 2 program suspended.
// - Bit 5 erase error, bit 4 program error; both mean bad sequence.
// - Bit 1 lock or protect abort, bit 3 low supply, set after operations.
`include "flash_cmd_params.svh"
module flash_command_interface import flash_cmd_pkg::*; #(
	parameter int ADDR_W = 10,
	parameter int OFFS_W = 6,
	parameter logic [7:0] CMD_READ_ARRAY = 8'hFF,
	parameter logic [7:0] CMD_READ_ID = 8'h90,
	parameter logic [7:0] CMD_READ_STATUS = 8'h70,
	parameter logic [7:0] CMD_CLEAR_STATUS = 8'h50,
	parameter logic [7:0] CMD_ERASE = 8'h20,
	parameter logic [7:0] CMD_PROGRAM = 8'h40,
	parameter logic [7:0] CMD_ERASE_SUSPEND = 8'hB0,
	parameter logic [7:0] CMD_PROG_SUSPEND = 8'hB1,
	parameter logic [7:0] CMD_RESUME = 8'hD0,
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'hA5 // Arbitrary value
) (
	input wire logic clk_sys_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset
	input wire logic wr_stb_i, // Host write cycle
	input wire logic rd_stb_i, // Host read cycle
	input wire logic [ADDR_W-1:0] addr_i, // Byte address
	input wire logic [7:0] wdata_i, // Command or program data
	output logic [7:0] rdata_o, // Read data
	output logic rvalid_o, // Read data valid
	input wire logic [(1<<(ADDR_W-OFFS_W))-1:0] write_lock_i, // Per-block write lock
	input wire logic top_block_protect_pin_n_i, // Top block protect pin
	input wire logic programming_supply_i, // Supply in range
	output status_t status_o // Live status byte
);
	localparam int NBLK = 1 << (ADDR_W - OFFS_W);
	localparam int BLK_W = ADDR_W - OFFS_W;
	localparam int PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	logic [2:0][1:0] sync_q;
	logic [1:0] pin_q, pin_d;
	read_mode_t mode_q, mode_d;
	wsm_state_t wsm_q, wsm_d;
	err_flags_t err_q, err_d, err_set;
	logic armed_q, armed_d, esusp_req_q, esusp_req_d, psusp_req_q, psusp_req_d, resume_pend_q, resume_pend_d;
	logic [BLK_W-1:0] er_blk_q, er_blk_d, wr_blk;
	logic [OFFS_W-1:0] er_idx_q, er_idx_d;
	logic [ADDR_W-1:0] pr_addr_q, pr_addr_d, mem_waddr;
	logic [7:0] pr_data_q, pr_data_d, pr_result, cnt_q, cnt_d, rdata_d, mem_wdata;
	logic busy, cmd_v, resume_hit, prot_active, supply_ok, clr, rvalid_d, mem_we;
	// Pins pass three flops; a level counts once stages two and three agree
	always_comb begin
		pin_d = (sync_q[1] & ~(sync_q[1] ^ sync_q[2])) | (pin_q & (sync_q[1] ^ sync_q[2]));
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync_q <= {3{`PIN_RESET}};
			pin_q <= `PIN_RESET;
		end else begin
			sync_q <= {sync_q[1:0], {programming_supply_i, top_block_protect_pin_n_i}};
			pin_q <= pin_d;
		end
	end
	assign prot_active = ~pin_q[0];
	assign supply_ok = pin_q[1];
	assign busy = (wsm_q == W_ERASE) || (wsm_q == W_PROG) || (wsm_q == W_ESUSP_PROG);
	assign cmd_v = wr_stb_i && !armed_q;
	assign resume_hit = cmd_v && (wdata_i == CMD_RESUME);
	assign wr_blk = addr_i[ADDR_W-1:OFFS_W];
	assign pr_result = mem[pr_addr_q] & pr_data_q; // Cells only move from one to zero
	// Block is write-protected by its lock bit or, for the top block, the pin
	function automatic logic blocked(input logic [BLK_W-1:0] blk, input logic [NBLK-1:0] lk, input logic p);
		blocked = lk[blk] | (p & (blk == BLK_W'(NBLK - 1)));
	endfunction
	// Command decode and write state machine
	always_comb begin
		mode_d = mode_q;
		wsm_d = wsm_q;
		armed_d = armed_q;
		esusp_req_d = esusp_req_q;
		psusp_req_d = psusp_req_q;
		resume_pend_d = resume_pend_q;
		er_blk_d = er_blk_q;
		er_idx_d = er_idx_q;
		pr_addr_d = pr_addr_q;
		pr_data_d = pr_data_q;
		cnt_d = cnt_q;
		err_set = '0;
		clr = 1'b0;
		mem_we = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;
		// Machine progress
		case (wsm_q)
			W_ERASE: begin
				if (esusp_req_q) begin
					wsm_d = W_ESUSP;
					esusp_req_d = 1'b0;
				end else begin
					mem_we = supply_ok;
					mem_waddr = {er_blk_q, er_idx_q};
					mem_wdata = `ERASED_BYTE;
					er_idx_d = er_idx_q + OFFS_W'(1);
					if (&er_idx_q) begin
						wsm_d = W_IDLE;
						err_set.supply_low = !supply_ok;
						err_set.erase_error = !supply_ok;
					end
				end
			end
			W_PROG, W_ESUSP_PROG: begin
				if (psusp_req_q && wsm_q == W_PROG) begin
					wsm_d = W_PSUSP;
					psusp_req_d = 1'b0;
				end else if (cnt_q == 8'h00) begin
					mem_we = supply_ok;
					mem_waddr = pr_addr_q;
					mem_wdata = pr_result;
					err_set.supply_low = !supply_ok;
					err_set.program_error = !supply_ok || (|(~pr_data_q & pr_result));
					if (wsm_q == W_ESUSP_PROG) begin
						wsm_d = (resume_pend_q || resume_hit) ? W_ERASE : W_ESUSP;
						resume_pend_d = 1'b0;
					end else begin
						wsm_d = W_IDLE;
					end
				end else begin
					cnt_d = cnt_q - 8'h01;
				end
			end
			default: ;
		endcase
		// Second write of a program sequence carries address and data
		if (wr_stb_i && armed_q) begin
			armed_d = 1'b0;
			mode_d = M_STATUS;
			pr_addr_d = addr_i;
			pr_data_d = wdata_i;
			if (wsm_q == W_ESUSP && wr_blk == er_blk_q) begin
				err_set.erase_error = 1'b1;
				err_set.program_error = 1'b1;
			end else if (blocked(wr_blk, write_lock_i, prot_active)) begin
				err_set.protect_abort = 1'b1;
				err_set.program_error = 1'b1;
			end else begin
				wsm_d = (wsm_q == W_ESUSP) ? W_ESUSP_PROG : W_PROG;
				cnt_d = 8'(PROG_CYCLES - 1);
			end
		end else if (cmd_v) begin
			case (wdata_i)
				CMD_READ_ARRAY: begin
					if (!busy) begin
						mode_d = M_ARRAY;
					end
				end
				CMD_READ_ID: begin
					if (wsm_q == W_IDLE) begin
						mode_d = M_IDENT;
					end
				end
				CMD_READ_STATUS: begin
					mode_d = M_STATUS;
				end
				CMD_CLEAR_STATUS: begin
					clr = (wsm_q == W_IDLE);
				end
				CMD_ERASE: begin
					mode_d = M_STATUS;
					if (wsm_q == W_IDLE) begin
						if (blocked(wr_blk, write_lock_i, prot_active)) begin
							err_set.protect_abort = 1'b1;
							err_set.erase_error = 1'b1;
						end else begin
							wsm_d = W_ERASE;
							er_blk_d = wr_blk;
							er_idx_d = '0;
						end
					end else if (wsm_q == W_ESUSP || wsm_q == W_PSUSP) begin
						err_set.erase_error = 1'b1;
						err_set.program_error = 1'b1;
					end
				end
				CMD_PROGRAM: begin
					if (wsm_q == W_IDLE || wsm_q == W_ESUSP) begin
						armed_d = 1'b1;
						mode_d = M_STATUS;
					end
				end
				CMD_ERASE_SUSPEND: begin
					if (wsm_q == W_ERASE) begin
						esusp_req_d = 1'b1;
						mode_d = M_STATUS;
					end
				end
				CMD_PROG_SUSPEND: begin
					if (wsm_q == W_PROG) begin
						psusp_req_d = 1'b1;
						mode_d = M_STATUS;
					end
				end
				CMD_RESUME: begin
					mode_d = (wsm_q == W_IDLE) ? mode_q : M_STATUS;
					if (wsm_q == W_PSUSP) begin
						wsm_d = W_PROG;
					end else if (wsm_q == W_ESUSP) begin
						wsm_d = W_ERASE;
					end else if (wsm_q == W_ESUSP_PROG && wsm_d == W_ESUSP_PROG) begin
						resume_pend_d = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// A request dies with the operation it was aimed at
		esusp_req_d = esusp_req_d && (wsm_d == W_ERASE);
		psusp_req_d = psusp_req_d && (wsm_d == W_PROG);
		// Set beats a clear landing in the same cycle
		err_d = (err_q & ~{4{clr}}) | err_set;
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mode_q <= M_ARRAY;
			wsm_q <= W_IDLE;
			err_q <= '0;
			armed_q <= 1'b0;
			esusp_req_q <= 1'b0;
			psusp_req_q <= 1'b0;
			resume_pend_q <= 1'b0;
			er_blk_q <= '0;
			er_idx_q <= '0;
			pr_addr_q <= '0;
			pr_data_q <= 8'h00;
			cnt_q <= 8'h00;
		end else begin
			mode_q <= mode_d;
			wsm_q <= wsm_d;
			err_q <= err_d;
			armed_q <= armed_d;
			esusp_req_q <= esusp_req_d;
			psusp_req_q <= psusp_req_d;
			resume_pend_q <= resume_pend_d;
			er_blk_q <= er_blk_d;
			er_idx_q <= er_idx_d;
			pr_addr_q <= pr_addr_d;
			pr_data_q <= pr_data_d;
			cnt_q <= cnt_d;
		end
	end
	// Array cells; contents are not cleared by reset, as in real flash
	always_ff @(posedge clk_sys_i) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end
	// Live status byte
	always_comb begin
		status_o.machine_ready_bit = !busy;
		status_o.erase_suspended_bit = (wsm_q == W_ESUSP) || (wsm_q == W_ESUSP_PROG);
		status_o.erase_error_bit = err_q.erase_error;
		status_o.program_error_bit = err_q.program_error;
		status_o.supply_low_bit = err_q.supply_low;
		status_o.program_suspended_bit = (wsm_q == W_PSUSP);
		status_o.protect_abort_bit = err_q.protect_abort;
		status_o.reserved = 1'b0;
	end
	// Read path; the suspended block or byte answers with status, not stale data
	always_comb begin
		rvalid_d = rd_stb_i;
		rdata_d = rdata_o;
		if (rd_stb_i) begin
			case (mode_q)
				M_ARRAY: begin
					if ((status_o.erase_suspended_bit && wr_blk == er_blk_q) ||
						(wsm_q == W_PSUSP && addr_i == pr_addr_q)) begin
						rdata_d = status_o;
					end else begin
						rdata_d = mem[addr_i];
					end
				end
				M_IDENT: begin
					rdata_d = (addr_i == ADDR_W'(`ID_MAKER_ADDR)) ? MAKER_CODE :
						((addr_i == ADDR_W'(`ID_DEVICE_ADDR)) ? DEVICE_CODE : 8'h00);
				end
				default: begin
					rdata_d = status_o;
				end
			endcase
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rdata_o <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rdata_o <= rdata_d;
			rvalid_o <= rvalid_d;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_reset_array_mode: assert property ($past(sys_rst_i) |-> mode_q == M_ARRAY) else $error("not array mode after reset");
	a_array_cmd_taken: assert property (cmd_v && wdata_i == CMD_READ_ARRAY && !busy |=> mode_q == M_ARRAY) else $error("array read lost");
	a_busy_ignores_array: assert property (cmd_v && wdata_i == CMD_READ_ARRAY && busy |=> $stable(mode_q)) else $error("array read taken while busy");
	a_ident_maker: assert property (rd_stb_i && mode_q == M_IDENT && addr_i == '0 |=> rdata_o == MAKER_CODE) else $error("bad maker code");
	a_status_cmd: assert property (cmd_v && wdata_i == CMD_READ_STATUS ##1 !wr_stb_i ##1 rd_stb_i |=> rdata_o == $past(status_o)) else $error("status not read");
	a_errors_fall_clear: assert property (|($past(err_q) & ~err_q) |-> $past(cmd_v && wdata_i == CMD_CLEAR_STATUS)) else $error("error flag dropped");
	a_erase_fills_ones: assert property (wsm_q == W_ERASE && !esusp_req_q && supply_ok |-> mem_we && mem_wdata == 8'hFF) else $error("erase byte not ones");
	a_lock_aborts: assert property (cmd_v && wdata_i == CMD_ERASE && wsm_q == W_IDLE && write_lock_i[wr_blk] |=> err_q.protect_abort && err_q.erase_error && wsm_q == W_IDLE) else $error("locked erase ran");
	a_erase_suspend: assert property (wsm_q == W_ERASE && esusp_req_q |=> wsm_q == W_ESUSP ##0 status_o.erase_suspended_bit) else $error("erase not suspended");
	a_ready_busy: assert property (wsm_q == W_PROG |-> !status_o.machine_ready_bit) else $error("ready while programming");
	c_erase_done: cover property (wsm_q == W_ERASE ##1 wsm_q == W_IDLE);
	c_prog_suspend: cover property (wsm_q == W_PSUSP ##[1:20] wsm_q == W_PROG);
	c_nested_prog: cover property (wsm_q == W_ESUSP_PROG ##[1:20] wsm_q == W_ERASE);
endmodule

/* bench/flash_host_model.sv */
`timescale 1ns/1ns
// Host memory-cycle driver: one write or read pulse at a time, launched 1 ns after an edge
module flash_host_model #(
	parameter int ADDR_W = 10
) (
	input wire logic clk_sys_i, // System clock
	output logic wr_stb_o, // Write cycle pulse
	output logic rd_stb_o, // Read cycle pulse
	output logic [ADDR_W-1:0] addr_o, // Byte address
	output logic [7:0] wdata_o, // Command or data byte
	input wire logic [7:0] rdata_i, // Read data
	input wire logic rvalid_i // Read data valid
);
	// Idle bus at time zero
	initial begin
		wr_stb_o = 1'b0;
		rd_stb_o = 1'b0;
		addr_o = '0;
		wdata_o = 8'h00;
	end

	// Address and data flip after release, so a stale value never passes for a fresh one
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		wr_stb_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		wr_stb_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// Read data is taken only in the one cycle that flags it valid
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#1;
		rd_stb_o = 1'b1;
		addr_o = a;
		@(posedge clk_sys_i);
		#1;
		rd_stb_o = 1'b0;
		addr_o = ~a;
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
	endtask
endmodule

/* bench/flash_command_interface_tb_top.sv */
`timescale 1ns/1ns
module flash_command_interface_tb_top import flash_cmd_pkg::*;;
	localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
	localparam logic [7:0] DEVID = 8'hA5; // Arbitrary value
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr_stb, rd_stb, rvalid;
	logic [9:0] addr;
	logic [7:0] wdata, rdata, got;
	logic [15:0] wlock = 16'h0000;
	logic prot_n = 1'b1;
	logic supply = 1'b1;
	status_t status;
	int err_total = 0;
	int comparisons = 0;

	// 250 MHz system clock
	always #2 clk_sys_i = ~clk_sys_i;

	flash_command_interface #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVID)) i_flash_command_interface (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb),
		.addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .write_lock_i(wlock),
		.top_block_protect_pin_n_i(prot_n), .programming_supply_i(supply), .status_o(status));

	flash_host_model #(.ADDR_W(10)) i_flash_host_model (
		.clk_sys_i(clk_sys_i), .wr_stb_o(wr_stb), .rd_stb_o(rd_stb), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));

	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t ns: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	// Bench inputs change 1 ns after an edge, like the host
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		i_flash_host_model.wr(a, d);
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [7:0] e, input string m);
		i_flash_host_model.rd(a, got);
		chk(got, e, m);
	endtask

	// Bounded wait for idle with no suspend; a suspended machine also shows the ready bit
	task automatic wait_ready;
		int n;
		n = 0;
		step(1);
		while (!(status.machine_ready_bit === 1'b1 && status.erase_suspended_bit === 1'b0 &&
			status.program_suspended_bit === 1'b0) && n < 200) begin
			step(1);
			n++;
		end
		// A machine that never settles is a mismatch, not a silent pass
		if (n >= 200) begin
			err_total++;
			$display("[FAIL] %0t ns: machine never became ready", $time);
		end
	endtask

	task automatic prog(input logic [9:0] a, input logic [7:0] d);
		wr(a, 8'h40);
		wr(a, d);
		wait_ready();
	endtask

	task automatic erase(input logic [9:0] a);
		wr(a, 8'h20);
		wait_ready();
	endtask

	task automatic clr(input string m);
		wr(10'h000, 8'h50);
		chk(status, 8'h80, m);
	endtask

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog: the sequence needs roughly 450 cycles
	initial begin
		#20000;
		err_total++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		conclude();
	end

	initial begin
		step(4);
		sys_rst_i = 1'b0;
		chk(status, 8'h80, "idle after reset");
		step(6);
		// Identifier mode and an unknown opcode
		wr(10'h000, 8'h90);
		rd_chk(10'h000, MAKER, "maker code");
		rd_chk(10'h001, DEVID, "device code");
		wr(10'h000, 8'h33);
		rd_chk(10'h000, MAKER, "mode after unknown opcode");
		// Erase block 2; array read refused while busy
		wr(10'h085, 8'h20);
		wr(10'h000, 8'hFF);
		i_flash_host_model.rd(10'h085, got);
		chk(got & 8'h80, 8'h00, "busy status during erase");
		wait_ready();
		rd_chk(10'h085, 8'h80, "status after erase");
		wr(10'h000, 8'hFF);
		for (int i = 0; i < 64; i++) rd_chk(10'h080 + 10'(i), 8'hFF, "erased byte");
		// Program, then program again: ones meant to stay are never flagged
		prog(10'h081, 8'h3C);
		rd_chk(10'h000, 8'h80, "status after program");
		prog(10'h081, 8'hF0);
		chk(status, 8'h80, "no verify error");
		wr(10'h000, 8'hFF);
		rd_chk(10'h081, 8'h30, "programmed byte");
		// Write lock on block 2
		wlock[2] = 1'b1;
		prog(10'h082, 8'h00);
		chk(status, 8'h92, "locked program");
		wr(10'h000, 8'hFF);
		rd_chk(10'h082, 8'hFF, "locked byte kept");
		clr("clear after program error");
		erase(10'h090);
		chk(status, 8'hA2, "locked erase");
		wlock[2] = 1'b0;
		clr("clear after lock abort");
		// Protect pin covers the top block
		prot_n = 1'b0;
		step(4);
		erase(10'h3C0);
		chk(status, 8'hA2, "protected erase");
		prot_n = 1'b1;
		step(4);
		clr("clear after protect abort");
		// Low supply: reads and clear still work, program aborts
		supply = 1'b0;
		step(5);
		wr(10'h000, 8'h90);
		rd_chk(10'h000, MAKER, "identifier at low supply");
		prog(10'h083, 8'h00);
		chk(status, 8'h98, "low supply program");
		wr(10'h000, 8'hFF);
		rd_chk(10'h083, 8'hFF, "byte kept at low supply");
		clr("clear at low supply");
		supply = 1'b1;
		step(5);
		// Erase suspend with a nested program and a refused erase
		wr(10'h0C0, 8'h20);
		wr(10'h000, 8'hB0);
		step(2);
		chk(status, 8'hC0, "erase suspended");
		wr(10'h000, 8'hFF);
		rd_chk(10'h081, 8'h30, "other block in erase suspend");
		rd_chk(10'h0C0, 8'hC0, "suspended block gives status");
		wr(10'h0C5, 8'h20);
		chk(status, 8'hF0, "erase while suspended");
		wr(10'h084, 8'h40);
		wr(10'h084, 8'h55);
		wr(10'h000, 8'hD0);
		wait_ready();
		chk(status, 8'hB0, "resumed erase done");
		clr("clear after sequence error");
		wr(10'h000, 8'hFF);
		rd_chk(10'h084, 8'h55, "nested program");
		rd_chk(10'h0C0, 8'hFF, "resumed block erased");
		// Program suspend
		wr(10'h085, 8'h40);
		wr(10'h085, 8'h0F);
		wr(10'h000, 8'hB1);
		step(2);
		chk(status, 8'h84, "program suspended");
		wr(10'h000, 8'hFF);
		rd_chk(10'h081, 8'h30, "other byte in program suspend");
		rd_chk(10'h085, 8'h84, "suspended byte gives status");
		wr(10'h000, 8'h70);
		rd_chk(10'h081, 8'h84, "status command in suspend");
		wr(10'h000, 8'hD0);
		wait_ready();
		chk(status, 8'h80, "resumed program done");
		wr(10'h000, 8'hFF);
		rd_chk(10'h085, 8'h0F, "resumed byte");
		// Second reset only once nothing is suspended; leave status mode so reset must restore array
		wr(10'h000, 8'h70);
		sys_rst_i = 1'b1;
		step(4);
		sys_rst_i = 1'b0;
		rd_chk(10'h081, 8'h30, "array mode after reset");
		conclude();
	end
endmodule
